// ### hdl/smlc_pkg.sv
package smlc_pkg;

  // ----------------------------------------------------------------
  // Word widths
  // ----------------------------------------------------------------
  localparam int CW_W       = 12;
  localparam int FL_W       = 4;
  localparam int SYN_W      = 8;
  localparam int MODEM_IN_W = 7;
  localparam int FIFO_DEPTH = 32;

  // ----------------------------------------------------------------
  // Line control status word bit positions (cpu bit 0 is the MSB)
  // ----------------------------------------------------------------
  localparam int B_INT    = 11;
  localparam int B_LOST   = 10;
  localparam int B_PAR    = 9;
  localparam int B_RTS    = 8;
  localparam int B_XREQ   = 7;
  localparam int B_CTS    = 6;
  localparam int B_CHKPAR = 5;
  localparam int B_TEXT   = 4;
  localparam int B_DSR    = 3;
  localparam int B_DTR    = 2;
  localparam int B_RING   = 1;
  localparam int B_CD     = 0;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  localparam logic [1:0] DEV_INT = 2'h0;
  localparam logic [1:0] DEV_CW1 = 2'h1;
  localparam logic [1:0] DEV_CW2 = 2'h2;
  localparam int P_FIRST  = 0;  // Pulse weight 1
  localparam int P_SECOND = 1;  // Pulse weight 2
  localparam int P_THIRD  = 2;  // Pulse weight 4

  // ----------------------------------------------------------------
  // Framing and reset values
  // ----------------------------------------------------------------
  localparam logic [SYN_W-1:0] SYN_CHAR    = 8'h16;
  localparam logic [FL_W-1:0]  FRAME_RESET = 4'h8;
  localparam logic [FL_W-1:0]  FRAME_LAST  = 4'hF;
  localparam logic [FL_W-1:0]  FRAME_STEP  = 4'h1;
  localparam logic [CW_W-1:0]  WORD_ZERO   = 12'h000;
  localparam logic [CW_W-1:0]  WORD_IDLE   = 12'hFFF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 20;
  localparam int CTS_SETTLE_NS  = 20000;
  localparam int CTS_SETTLE_CYC = (CTS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CTS_CNT_W      = $clog2(CTS_SETTLE_CYC + 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LS_OFF  = 2'b00,
    LS_IDLE = 2'b01,
    LS_RX   = 2'b11,
    LS_TX   = 2'b10
  } smlc_line_state_t;

  typedef struct packed {
    logic            valid;
    logic [1:0]      dev;
    logic [2:0]      pulse;
    logic [CW_W-1:0] ac;
  } smlc_iot_req_t;

  typedef struct packed {
    logic            valid;
    logic            skip;
    logic [CW_W-1:0] ac;
  } smlc_iot_rsp_t;

  typedef struct packed {
    logic tx_clk;
    logic rx_clk;
    logic rx_data;
    logic cts;
    logic dsr;
    logic ring;
    logic cd;
  } smlc_modem_in_t;

endpackage

// ### hdl/smlc_sync2.sv
`timescale 1ns/1ps
module smlc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  // Two-flop synchroniser; stage1 feeds only stage2
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // smlc_sync2

// ### hdl/smlc_fifo.sv
`timescale 1ns/1ps
module smlc_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 32
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] in_data_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  output logic      [W-1:0] out_data_out,
  output logic              out_valid_out,
  input  wire logic         out_ready_in
);

  // DEPTH must be a power of two; pointers wrap naturally
  localparam int            AW       = $clog2(DEPTH);
  localparam logic [AW:0]   CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0]   CNT_ONE  = (AW+1)'(1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  assign in_ready_out = (count != CNT_FULL);
  assign push         = in_valid_in & in_ready_out;
  assign pop          = (count != '0) && (!out_valid_out || out_ready_in);

  // Storage array, no reset needed
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem[wptr] <= in_data_in;
  end

  // Pointers and fill count
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wptr <= wptr + 1'b1;
      if (pop)
        rptr <= rptr + 1'b1;
      if (push && !pop)
        count <= count + CNT_ONE;
      else if (pop && !push)
        count <= count - CNT_ONE;
    end
  end

  // Registered output stage holds the head word
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end
    else if (pop)
    begin
      out_valid_out <= 1'b1;
      out_data_out  <= mem[rptr];
    end
    else if (out_ready_in)
      out_valid_out <= 1'b0;
  end

endmodule // smlc_fifo

// ### hdl/smlc_line_control.sv
`timescale 1ns/1ps
// Functional notes
// - Identify pulses skip on pending transmit or receive interrupt.
// - Clear-interrupts resets transmit, receive and character service flags.
// - Reading a control word ORs it into the working register.
// - Skip-under-mask skips when a mask bit is one and word bit zero.
// - Invert-under-mask complements each writable bit whose mask bit is one; interrupt, overrun and parity fault only clear.
// - Both control words share read, skip and invert behaviour by device code.
// - Frame length word holds four-bit modulo-16 complement of frame size.
// - Interrupt flag sets exactly when a character is delivered or fetched.
// - Overrun sets on a character event while interrupt flag still set.
// - Parity fault sets on a received parity error only when enabled.
// - Request-to-send drives carrier request; hardware controls it from transmit request.
// - Request-to-send waits for receive character end; drops at transmit character end.
// - Send permit is a settled indication derived from the raw line.
// - Parity computed always; checked on receive and appended on transmit when enabled.
// - Sync sets text; clearing text re-hunts; no interrupts while hunting.
// - Text cleared in transmit freezes the line bit and interrupts.
// - Terminal-ready is invertible and drives the modem auto-answer line.
// - Status bits mirror data-set-ready, ringing and carrier detect inputs.
// - Transmit state when all five handshake conditions hold.
// - Receive state when no request or permit, set ready and carrier.
// - Receive-idle when no request or permit and set ready.
// - Hunting scans incoming bits for the sync pattern.
// - Counter overflow moves the character, sets interrupt, reloads counter.
module smlc_line_control
  import smlc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire smlc_iot_req_t   iot_req_in,
  output smlc_iot_rsp_t        iot_rsp_out,
  input  wire smlc_modem_in_t  modem_in,
  output logic                 rts_out,
  output logic                 dtr_out,
  output logic                 tx_line_out,
  output logic                 int_req_out,
  output logic      [CW_W-1:0] rx_char_data_out,
  output logic                 rx_char_valid_out,
  input  wire logic            rx_char_ready_in,
  input  wire logic [CW_W-1:0] tx_char_data_in,
  input  wire logic            tx_char_valid_in,
  output logic                 tx_char_ready_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  smlc_modem_in_t   modem_s;
  logic             tx_clk_prev;
  logic             rx_clk_prev;
  logic             tx_tick;
  logic             rx_tick;
  smlc_line_state_t line_state;
  smlc_line_state_t next_line_state;
  logic             int_flag;
  logic             tx_pend;
  logic             rx_pend;
  logic             lost;
  logic             par_fault;
  logic             xreq;
  logic             parity_enable_bit;
  logic             text;
  logic             dtr;
  logic             rts;
  logic             dcts;
  logic [CTS_CNT_W-1:0] cts_cnt;
  logic [FL_W-1:0]  frame_len;
  logic [FL_W-1:0]  frame_cnt;
  logic [CW_W-1:0]  shreg;
  logic             par_acc;
  logic             frame_end;
  logic             rx_char_end;
  logic             tx_char_end;
  logic             char_evt;
  logic             sync_hit;
  logic             rx_par_bad;
  logic             tx_bit;
  logic [CW_W-1:0]  cw1;
  logic [CW_W-1:0]  sel_word;
  logic             iot_int;
  logic             iot_cw1;
  logic             iot_cw2;
  logic             clr_int;
  logic [CW_W-1:0]  inv_mask;
  logic             fifo_ready;
  logic             enter_rx;
  logic             enter_tx;

  // ----------------------------------------------------------------
  // Modem pin synchronisation and clock edge detection
  // ----------------------------------------------------------------
  smlc_sync2 #(
    .W (MODEM_IN_W)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in (modem_in),
    .sync_out (modem_s)
  );

  // Previous clock levels, taken after the synchroniser only
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      tx_clk_prev <= 1'b0;
      rx_clk_prev <= 1'b0;
    end
    else
    begin
      tx_clk_prev <= modem_s.tx_clk;
      rx_clk_prev <= modem_s.rx_clk;
    end
  end

  // Bit ticks gated by the current line state; the clock choice follows the state
  assign tx_tick = modem_s.tx_clk & ~tx_clk_prev & (line_state == LS_TX);
  assign rx_tick = modem_s.rx_clk & ~rx_clk_prev & (line_state == LS_RX);

  // ----------------------------------------------------------------
  // Line state
  // ----------------------------------------------------------------
  // Priority follows the conjunctions; states change only on the clock
  always_comb
  begin
    if (rts && dcts && modem_s.dsr && dtr && modem_s.cd)
      next_line_state = LS_TX;
    else if (!rts && !dcts && modem_s.dsr && modem_s.cd)
      next_line_state = LS_RX;
    else if (!rts && !dcts && modem_s.dsr)
      next_line_state = LS_IDLE;
    else
      next_line_state = LS_OFF;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      line_state <= LS_OFF;
    else
      line_state <= next_line_state;
  end

  assign enter_rx = (next_line_state == LS_RX) && (line_state != LS_RX);
  assign enter_tx = (next_line_state == LS_TX) && (line_state != LS_TX);

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  assign iot_int  = iot_req_in.valid && (iot_req_in.dev == DEV_INT);
  assign iot_cw1  = iot_req_in.valid && (iot_req_in.dev == DEV_CW1);
  assign iot_cw2  = iot_req_in.valid && (iot_req_in.dev == DEV_CW2);
  assign clr_int  = iot_int && iot_req_in.pulse[P_THIRD];
  assign inv_mask = iot_cw1 && iot_req_in.pulse[P_THIRD] ? iot_req_in.ac : WORD_ZERO;

  // Status word image; read-only bits come straight from their sources
  always_comb
  begin
    cw1           = WORD_ZERO;
    cw1[B_INT]    = int_flag;
    cw1[B_LOST]   = lost;
    cw1[B_PAR]    = par_fault;
    cw1[B_RTS]    = rts;
    cw1[B_XREQ]   = xreq;
    cw1[B_CTS]    = dcts;
    cw1[B_CHKPAR] = parity_enable_bit;
    cw1[B_TEXT]   = text;
    cw1[B_DSR]    = modem_s.dsr;
    cw1[B_DTR]    = dtr;
    cw1[B_RING]   = modem_s.ring;
    cw1[B_CD]     = modem_s.cd;
  end

  // Selected control word; frame length sits in the low bits
  always_comb
  begin
    if (iot_cw1)
      sel_word = cw1;
    else if (iot_cw2)
      sel_word = {{(CW_W-FL_W){1'b0}}, frame_len};
    else
      sel_word = WORD_ZERO;
  end

  // Answer one cycle later; read and skip see values before any invert
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      iot_rsp_out <= '0;
    else
    begin
      iot_rsp_out.valid <= iot_req_in.valid;
      if (iot_int)
      begin
        iot_rsp_out.ac   <= iot_req_in.ac;
        iot_rsp_out.skip <= (iot_req_in.pulse[P_FIRST] && tx_pend) ||
                            (iot_req_in.pulse[P_SECOND] && rx_pend);
      end
      else
      begin
        iot_rsp_out.ac   <= iot_req_in.pulse[P_FIRST] ? (iot_req_in.ac | sel_word) : iot_req_in.ac;
        iot_rsp_out.skip <= (iot_cw1 || iot_cw2) && iot_req_in.pulse[P_SECOND] &&
                            ((iot_req_in.ac & ~sel_word) != WORD_ZERO);
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame length word
  // ----------------------------------------------------------------
  // Software keeps the size between three and twelve bits; not checked here
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      frame_len <= FRAME_RESET;
    else if (iot_cw2 && iot_req_in.pulse[P_THIRD])
      frame_len <= frame_len ^ iot_req_in.ac[FL_W-1:0];
  end

  // ----------------------------------------------------------------
  // Software-invertible control bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      xreq    <= 1'b0;
      parity_enable_bit <= 1'b0;
      dtr     <= 1'b0;
    end
    else
    begin
      xreq    <= xreq ^ inv_mask[B_XREQ];
      parity_enable_bit <= parity_enable_bit ^ inv_mask[B_CHKPAR];
      dtr     <= dtr ^ inv_mask[B_DTR];
    end
  end

  assign dtr_out = dtr;

  // Text: hardware sets on sync and on entry to transmit, clears on entry
  // to receive so a fresh message is hunted; hardware wins over software
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      text <= 1'b0;
    else if (sync_hit || enter_tx)
      text <= 1'b1;
    else if (enter_rx)
      text <= 1'b0;
    else
      text <= text ^ inv_mask[B_TEXT];
  end

  // ----------------------------------------------------------------
  // Request-to-send and derived send permit
  // ----------------------------------------------------------------
  // Hunting counts as not actively receiving, so no character end is awaited
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rts <= 1'b0;
    else if (xreq && !rts && (line_state != LS_RX || !text || rx_char_end))
      rts <= 1'b1;
    else if (!xreq && rts && (line_state != LS_TX || tx_char_end))
      rts <= 1'b0;
  end

  assign rts_out = rts;

  // Permit only after the raw line has held with request asserted
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      cts_cnt <= '0;
    else if (!(rts && modem_s.cts))
      cts_cnt <= '0;
    else if (!dcts)
      cts_cnt <= cts_cnt + 1'b1;
  end

  assign dcts = (cts_cnt == CTS_CNT_W'(CTS_SETTLE_CYC));

  // ----------------------------------------------------------------
  // Frame counter, shift register and parity
  // ----------------------------------------------------------------
  assign frame_end   = (frame_cnt == FRAME_LAST);
  assign rx_char_end = rx_tick && text && frame_end;
  assign tx_char_end = tx_tick && text && frame_end;
  assign char_evt    = rx_char_end || tx_char_end;

  // Hunt compares the newest eight bits including the one arriving now
  assign sync_hit   = rx_tick && !text &&
                      ({shreg[SYN_W-2:0], modem_s.rx_data} == SYN_CHAR);
  // Even parity over the whole frame including the parity position
  assign rx_par_bad = par_acc ^ modem_s.rx_data;
  // Parity replaces the high-order position when enabled
  assign tx_bit     = (parity_enable_bit && frame_end) ? par_acc : shreg[0];

  // Transmit fetch happens only at character end
  assign tx_char_ready_out = tx_char_end;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      frame_cnt <= FRAME_RESET;
      shreg     <= WORD_ZERO;
      par_acc   <= 1'b0;
    end
    else if (enter_rx || enter_tx)
    begin
      frame_cnt <= frame_len;
      shreg     <= WORD_IDLE;
      par_acc   <= 1'b0;
    end
    else if (rx_tick)
    begin
      shreg <= {shreg[CW_W-2:0], modem_s.rx_data};
      if (sync_hit || rx_char_end)
      begin
        frame_cnt <= frame_len;
        par_acc   <= 1'b0;
      end
      else if (text)
      begin
        frame_cnt <= frame_cnt + FRAME_STEP;
        par_acc   <= par_acc ^ modem_s.rx_data;
      end
    end
    else if (tx_tick && text)
    begin
      if (frame_end)
      begin
        frame_cnt <= frame_len;
        par_acc   <= 1'b0;
        shreg     <= tx_char_valid_in ? tx_char_data_in : WORD_IDLE;
      end
      else
      begin
        frame_cnt <= frame_cnt + FRAME_STEP;
        par_acc   <= par_acc ^ shreg[0];
        shreg     <= {1'b0, shreg[CW_W-1:1]};
      end
    end
  end

  // Line driver holds its bit while frozen; zeros while receiving
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      tx_line_out <= 1'b0;
    else if (line_state != LS_TX)
      tx_line_out <= 1'b0;
    else if (tx_tick && text)
      tx_line_out <= tx_bit;
  end

  // ----------------------------------------------------------------
  // Receive character buffer
  // ----------------------------------------------------------------
  // A full buffer drops the character and reports it as overrun
  smlc_fifo #(
    .W     (CW_W),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_data_in    ({shreg[CW_W-2:0], modem_s.rx_data}),
    .in_valid_in   (rx_char_end),
    .in_ready_out  (fifo_ready),
    .out_data_out  (rx_char_data_out),
    .out_valid_out (rx_char_valid_out),
    .out_ready_in  (rx_char_ready_in)
  );

  // ----------------------------------------------------------------
  // Interrupt and error flags; a set in the clear cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      int_flag <= 1'b0;
      tx_pend  <= 1'b0;
      rx_pend  <= 1'b0;
    end
    else
    begin
      if (char_evt)
        int_flag <= 1'b1;
      else if (clr_int || inv_mask[B_INT])
        int_flag <= 1'b0;
      if (tx_char_end)
        tx_pend <= 1'b1;
      else if (clr_int)
        tx_pend <= 1'b0;
      if (rx_char_end)
        rx_pend <= 1'b1;
      else if (clr_int)
        rx_pend <= 1'b0;
    end
  end

  assign int_req_out = int_flag;

  // Overrun and parity fault may only be cleared by software
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      lost      <= 1'b0;
      par_fault <= 1'b0;
    end
    else
    begin
      if ((char_evt && int_flag) || (rx_char_end && !fifo_ready))
        lost <= 1'b1;
      else if (inv_mask[B_LOST])
        lost <= 1'b0;
      if (rx_char_end && parity_enable_bit && rx_par_bad)
        par_fault <= 1'b1;
      else if (inv_mask[B_PAR])
        par_fault <= 1'b0;
    end
  end

endmodule // smlc_line_control

// ### tb/smlc_asserts.sv
`timescale 1ns/1ps
module smlc_asserts
  import smlc_pkg::*;
(
  input wire logic          clk_in,
  input wire logic          rst_in,
  input wire smlc_iot_req_t iot_req_in,
  input wire smlc_iot_rsp_t iot_rsp_out,
  input wire logic          rts_out,
  input wire logic          dtr_out,
  input wire logic          tx_line_out,
  input wire logic          int_req_out,
  input wire logic          tx_char_ready_out
);
  // ----------------------------------------------------------------
  // Decoded requests
  // ----------------------------------------------------------------
  logic rd_w;
  logic inv_dtr;
  logic clr_int;
  assign rd_w    = iot_req_in.valid && iot_req_in.dev inside {DEV_CW1, DEV_CW2} && iot_req_in.pulse == 3'h1;
  assign inv_dtr = iot_req_in.valid && iot_req_in.dev == DEV_CW1 && iot_req_in.pulse[P_THIRD] && iot_req_in.ac[B_DTR];
  // Both the group clear and a masked clear of the flag count, so a held flag is never mistaken
  assign clr_int = iot_req_in.valid && iot_req_in.pulse[P_THIRD] &&
                   (iot_req_in.dev == DEV_INT || (iot_req_in.dev == DEV_CW1 && iot_req_in.ac[B_INT]));
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_rts_low;
    !rts_out [*4];
  endsequence
  a_rsp_one_cycle: assert property (iot_rsp_out.valid == $past(iot_req_in.valid))
    else $error("response strobe not one cycle after request");
  a_read_keeps_ac: assert property (rd_w |=> (iot_rsp_out.ac & $past(iot_req_in.ac)) == $past(iot_req_in.ac))
    else $error("read lost working register bits");
  a_spare_dev_echo: assert property (iot_req_in.valid && iot_req_in.dev == 2'h3 |=>
    iot_rsp_out.ac == $past(iot_req_in.ac) && !iot_rsp_out.skip)
    else $error("spare device code had an effect");
  a_skip_zero_mask: assert property (iot_req_in.valid && iot_req_in.dev != DEV_INT && iot_req_in.pulse == 3'h2 &&
    iot_req_in.ac == WORD_ZERO |=> !iot_rsp_out.skip)
    else $error("skip with empty mask");
  a_cw2_upper_zero: assert property (rd_w && iot_req_in.dev == DEV_CW2 && iot_req_in.ac == WORD_ZERO |=>
    iot_rsp_out.ac[CW_W-1:FL_W] == 8'h00)
    else $error("frame length word shows upper bits");
  a_int_holds_set: assert property (int_req_out && !clr_int && !$past(clr_int) |=> int_req_out)
    else $error("interrupt flag dropped without a clear");
  a_fetch_raises_int: assert property (tx_char_ready_out |-> ##[1:2] int_req_out)
    else $error("character fetch raised no interrupt");
  a_fetch_one_pulse: assert property (tx_char_ready_out |=> !tx_char_ready_out)
    else $error("fetch strobe longer than one cycle");
  a_dtr_follows_inv: assert property (inv_dtr |-> ##[1:2] $changed(dtr_out))
    else $error("terminal ready did not invert");
  a_dtr_needs_cause: assert property ($changed(dtr_out) |-> $past(inv_dtr) || $past(inv_dtr, 2))
    else $error("terminal ready changed without invert");
  a_line_quiet: assert property (s_rts_low |-> !tx_line_out)
    else $error("transmit line active outside transmit");
endmodule // smlc_asserts

bind smlc_line_control smlc_asserts u_chk (.clk_in(clk_in), .rst_in(rst_in), .iot_req_in(iot_req_in),
  .iot_rsp_out(iot_rsp_out), .rts_out(rts_out), .dtr_out(dtr_out), .tx_line_out(tx_line_out),
  .int_req_out(int_req_out), .tx_char_ready_out(tx_char_ready_out));

// ### tb/smlc_modem_model.sv
`timescale 1ns/1ps
module smlc_modem_model
  import smlc_pkg::*;
(
  input  wire logic      rts_in,
  input  wire logic      dsr_in,
  input  wire logic      ring_in,
  input  wire logic      cd_in,
  output smlc_modem_in_t modem_out
);
  logic tx_clk = 1'b0;
  logic rx_clk = 1'b0;
  logic rx_data = 1'b0;
  logic cts = 1'b0;
  // Transmit clock runs free, the set needs it for its own timing
  initial forever #80 tx_clk = ~tx_clk;
  // Raw clear-to-send comes back well before the settled permit may rise
  always @(rts_in) cts <= #2000 rts_in;
  // Local carrier shows while our own carrier is up
  assign modem_out = '{tx_clk: tx_clk, rx_clk: rx_clk, rx_data: rx_data, cts: cts, dsr: dsr_in, ring: ring_in,
                       cd: cd_in | cts};
  // Receive clock stands still between characters; line then shows the inverse of its last bit
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      rx_data = b[i];
      #80 rx_clk = 1'b1;
      #80 rx_clk = 1'b0;
    end
    rx_data = ~rx_data;
  endtask
endmodule // smlc_modem_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import smlc_pkg::*;
;
  logic            clk_in = 1'b0;
  logic            rst_in = 1'b1;
  smlc_iot_req_t   req = '0;
  smlc_iot_rsp_t   rsp;
  smlc_modem_in_t  modem;
  logic            rts, dtr, txl, irq, rxv, txr;
  logic [CW_W-1:0] rxd;
  logic            rxr = 1'b0, txv = 1'b1, dsr = 1'b0, ring = 1'b0, cd = 1'b0;
  int              err_count = 0, n_compared = 0, n;
  smlc_modem_model mdm (.rts_in(rts), .dsr_in(dsr), .ring_in(ring), .cd_in(cd), .modem_out(modem));
  smlc_line_control dut (.clk_in(clk_in), .rst_in(rst_in), .iot_req_in(req), .iot_rsp_out(rsp), .modem_in(modem),
    .rts_out(rts), .dtr_out(dtr), .tx_line_out(txl), .int_req_out(irq), .rx_char_data_out(rxd),
    .rx_char_valid_out(rxv), .rx_char_ready_in(rxr), .tx_char_data_in(12'h0C3), .tx_char_valid_in(txv),
    .tx_char_ready_out(txr));
  initial forever #10 clk_in = ~clk_in;
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [CW_W-1:0] seen, input logic [CW_W-1:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One instruction; the answer is settled 1 ns after the taking edge
  task automatic xfer(input logic [1:0] dv, input logic [2:0] pl, input logic [CW_W-1:0] ac);
    @(posedge clk_in);
    req <= '{valid: 1'b1, dev: dv, pulse: pl, ac: ac};
    @(posedge clk_in);
    req.valid <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [1:0] dv, input logic [CW_W-1:0] ac, input logic [CW_W-1:0] exp);
    xfer(dv, 3'h1, ac);
    chk("read word", rsp.ac, exp);
  endtask
  task automatic sk(input logic [1:0] dv, input logic [2:0] pl, input logic [CW_W-1:0] ac, input logic exp);
    xfer(dv, pl, ac);
    chk("skip", {11'h000, rsp.skip}, {11'h000, exp});
  endtask
  // Bounded wait for a pin to reach a level
  task automatic wait_pin(ref logic s, input logic lv);
    n = 0;
    while (s !== lv && n < 3000)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
  endtask
  task automatic results;
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(DEV_CW1, 12'h000, 12'h000);
    rd(DEV_CW2, 12'hF00, 12'hF08);
    sk(DEV_CW2, 3'h2, 12'h008, 1'b0);
    sk(DEV_CW2, 3'h2, 12'h004, 1'b1);
    sk(2'h3, 3'h3, 12'h5A5, 1'b0);
    chk("spare echo", rsp.ac, 12'h5A5);
    xfer(DEV_CW2, 3'h4, 12'h00C);
    rd(DEV_CW2, 12'h000, 12'h004);
    xfer(DEV_CW2, 3'h4, 12'h00C);
    xfer(DEV_CW1, 3'h4, 12'hF4F);
    rd(DEV_CW1, 12'h000, 12'h004);
    chk("dtr pin", {11'h000, dtr}, 12'h001);
    @(posedge clk_in);
    dsr <= 1'b1;
    ring <= 1'b1;
    cd <= 1'b1;
    repeat (8) @(posedge clk_in);
    rd(DEV_CW1, 12'h000, 12'h00F);
    mdm.send(8'h16);
    mdm.send(8'hA5);
    repeat (10) @(posedge clk_in);
    chk("int pin", {11'h000, irq}, 12'h001);
    rd(DEV_CW1, 12'h000, 12'h81F);
    sk(DEV_INT, 3'h2, 12'h000, 1'b1);
    sk(DEV_INT, 3'h1, 12'h000, 1'b0);
    mdm.send(8'h3C);
    repeat (10) @(posedge clk_in);
    rd(DEV_CW1, 12'h000, 12'hC1F);
    chk("rx char 0", rxd & 12'h0FF, 12'h0A5);
    rxr <= 1'b1;
    @(posedge clk_in);
    rxr <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("rx char 1", rxd & 12'h0FF, 12'h03C);
    chk("rx valid", {11'h000, rxv}, 12'h001);
    rxr <= 1'b1;
    xfer(DEV_INT, 3'h4, 12'h000);
    sk(DEV_INT, 3'h2, 12'h000, 1'b0);
    rd(DEV_CW1, 12'h000, 12'h41F);
    xfer(DEV_CW1, 3'h4, 12'h480);
    repeat (5) @(posedge clk_in);
    chk("rts held", {11'h000, rts}, 12'h000);
    mdm.send(8'h5A);
    repeat (10) @(posedge clk_in);
    chk("rts at end", {11'h000, rts}, 12'h001);
    repeat (200) @(posedge clk_in);
    xfer(DEV_INT, 3'h4, 12'h000);
    rd(DEV_CW1, 12'h000, 12'h19F);
    wait_pin(txr, 1'b1);
    chk("fetch", {11'h000, txr}, 12'h001);
    chk("line mark", {11'h000, txl}, 12'h001);
    repeat (3) @(posedge clk_in);
    sk(DEV_INT, 3'h1, 12'h000, 1'b1);
    xfer(DEV_CW1, 3'h1, 12'h000);
    chk("tx state", rsp.ac & 12'h950, 12'h950);
    xfer(DEV_CW1, 3'h4, 12'h080);
    chk("rts kept", {11'h000, rts}, 12'h001);
    wait_pin(rts, 1'b0);
    chk("rts dropped", {11'h000, rts}, 12'h000);
    results();
  end
  // Full run is near 1600 cycles; the limit leaves wide margin
  initial
  begin
    #400000;
    err_count++;
    results();
  end
endmodule // tb_top
